// ===== ast_timer.sv
// sixteen_bit_timer: counter, clock selection, special event reset and registers
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ast_timer
  import ast_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [AST_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // processor state
  input wire logic sleep,
  // external clock and crystal pins
  input wire logic ext_clk,
  input wire logic crystal_input_pin,
  output logic crystal_amp_output_pin,
  output logic crystal_amp_oe,
  // towards the capture_compare_unit and the core
  output logic timebase_valid,
  output logic special_event,
  output logic irq,
  output logic wake
);
  // control and compare registers
  logic [AST_CTL_W-1:0] ctrl;
  logic [AST_FLAG_W-1:0] mask;
  logic [7:0] cmp_lo;
  logic [7:0] cmp_hi;
  logic [AST_MODE_W-1:0] cmp_mode;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;

  // clock sources after synchronization
  logic ext_level;
  logic ext_rise;
  logic xtal_level;
  logic xtal_rise;
  logic src_rise;
  logic sync_tick;

  // decoded conditions
  logic timer_on;
  logic ext_sel;
  logic unsync;
  logic osc_en;
  logic inc_tick;
  logic special_hit;
  logic ovf_evt;
  logic wr_lo;
  logic wr_hi;
  logic rd_flag;
  logic [AST_FLAG_W-1:0] status;
  logic [AST_FLAG_W-1:0] ovf_set;

  // both pin clocks pass two flops before any logic reads them
  ast_sync u_ext_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(ext_clk),
    .level(ext_level),
    .rise(ext_rise)
  );

  ast_sync u_xtal_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(crystal_input_pin),
    .level(xtal_level),
    .rise(xtal_rise)
  );

  // control field decode
  assign timer_on = ctrl[AST_CTL_ON];
  assign ext_sel = ctrl[AST_CTL_EXT];
  assign osc_en = ctrl[AST_CTL_OSC_EN];
  assign unsync = ext_sel & ctrl[AST_CTL_SYNC_DIS];
  assign wr_lo = wr && (addr == AST_OFS_CNT_LO);
  assign wr_hi = wr && (addr == AST_OFS_CNT_HI);
  assign rd_flag = rd && (addr == AST_OFS_FLAG);

  // byte views of the count for the register side
  assign count_low_byte = count[7:0];
  assign count_high_byte = count[15:8];

  // the crystal replaces the external clock pin while its oscillator runs
  assign src_rise = osc_en ? xtal_rise : ext_rise;

  // synchronized mode aligns each edge to the core phase once more
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_tick <= 1'b0;
    end else begin
      sync_tick <= src_rise;
    end
  end

  // increment source: core clock, realigned edge or the two-flop synchronizer edge without realignment
  always_comb begin
    if (!timer_on) begin
      inc_tick = 1'b0;
    end else if (!ext_sel) begin
      inc_tick = ~sleep;
    end else if (unsync) begin
      inc_tick = src_rise;
    end else begin
      inc_tick = sync_tick & ~sleep;
    end
  end

  // compare pair as period: trigger fires on match, not in unsync mode
  assign special_hit = (cmp_mode == AST_MODE_SPECIAL) && !unsync
    && (count == {cmp_hi, cmp_lo});

  // rollover only by counting, never by the trigger or a write
  assign ovf_evt = inc_tick && (count == AST_CNT_MAX) && !special_hit
    && !wr_lo && !wr_hi;
  // place the rollover event on its own flag bit, the rest stay clear
  always_comb begin
    ovf_set = '0;
    ovf_set[AST_FLAG_OVF] = ovf_evt;
  end

  // a write beats the trigger; trigger beats an increment
  always_comb begin
    next_count = count;
    if (wr_lo) begin
      next_count = {count[15:8], wdata};
    end else if (wr_hi) begin
      next_count = {wdata, count[7:0]};
    end else if (special_hit) begin
      next_count = AST_CNT_ZERO;
    end else if (inc_tick) begin
      next_count = count + AST_CNT_ONE;
    end
  end

  // the count itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= AST_CNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  // control and compare registers written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= AST_CTL_RST;
      mask <= '0;
      cmp_lo <= AST_BYTE_ZERO;
      cmp_hi <= AST_BYTE_ZERO;
      cmp_mode <= AST_MODE_RST;
    end else if (wr) begin
      unique case (addr)
        AST_OFS_CTRL: ctrl <= wdata[AST_CTL_W-1:0];
        AST_OFS_MASK: mask <= wdata[AST_FLAG_W-1:0];
        AST_OFS_CMP_LO: cmp_lo <= wdata;
        AST_OFS_CMP_HI: cmp_hi <= wdata;
        AST_OFS_CMP_MODE: cmp_mode <= wdata[AST_MODE_W-1:0];
        default: ;
      endcase
    end
  end

  // overflow flag, cleared by reading the flag register
  ast_irq #(
    .N(AST_FLAG_W)
  ) u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .set(ovf_set),
    .clr(rd_flag),
    .mask(mask),
    .status(status),
    .irq(irq)
  );

  // read data one cycle after the strobe; the count lives in this domain,
  // so each byte is always a settled value even with a pin clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= AST_BYTE_ZERO;
    end else if (rd) begin
      unique case (addr)
        AST_OFS_CNT_LO: rdata <= count_low_byte;
        AST_OFS_CNT_HI: rdata <= count_high_byte;
        AST_OFS_CTRL: rdata <= 8'(ctrl);
        AST_OFS_FLAG: rdata <= 8'(status);
        AST_OFS_MASK: rdata <= 8'(mask);
        AST_OFS_CMP_LO: rdata <= cmp_lo;
        AST_OFS_CMP_HI: rdata <= cmp_hi;
        AST_OFS_CMP_MODE: rdata <= 8'(cmp_mode);
        default: rdata <= AST_BYTE_ZERO;
      endcase
    end else begin
      rdata <= AST_BYTE_ZERO;
    end
  end

  // crystal amplifier: inverting stage, not gated by sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_amp_output_pin <= 1'b0;
      crystal_amp_oe <= 1'b0;
    end else begin
      crystal_amp_output_pin <= osc_en & ~xtal_level;
      crystal_amp_oe <= osc_en;
    end
  end

  // side outputs to the compare unit and the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timebase_valid <= 1'b0;
      special_event <= 1'b0;
      wake <= 1'b0;
    end else begin
      timebase_valid <= ~unsync;
      special_event <= special_hit;
      wake <= irq & sleep;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_write_wins_trig: assert property (
    (wr_lo && special_hit) |=> (count[7:0] == $past(wdata)))
    else $error("count write lost to special trigger");

  a_special_clears: assert property (
    (special_hit && !wr_lo && !wr_hi) |=> (count == AST_CNT_ZERO))
    else $error("special trigger did not clear count");

  a_trig_no_flag: assert property (
    (special_hit && (status == '0) && !ovf_evt) |=> (status == '0))
    else $error("special trigger set overflow flag");

  a_ovf_sets_flag: assert property (
    (count == AST_CNT_MAX && inc_tick && !special_hit && !wr)
      |=> (count == AST_CNT_ZERO) && status[AST_FLAG_OVF])
    else $error("rollover did not set overflow flag");

  a_unsync_no_base: assert property (
    unsync |=> !timebase_valid)
    else $error("time base offered in unsync mode");

  a_unsync_no_trig: assert property (
    unsync |-> !special_hit)
    else $error("special trigger in unsync mode");

  a_sleep_stops_sync: assert property (
    (sleep && !unsync) |-> !inc_tick)
    else $error("synchronized count advanced in sleep");

  a_unsync_edge_count: assert property (
    (unsync && timer_on && src_rise && !wr && !sleep) |=> (count == $past(count) + AST_CNT_ONE))
    else $error("unsync edge not counted");

  a_unsync_sleep_runs: assert property (
    (unsync && timer_on && src_rise && sleep && !wr) |=> (count == $past(count) + AST_CNT_ONE))
    else $error("unsync count stopped in sleep");

  a_sync_two_stage: assert property (
    (ext_sel && !unsync && timer_on && !sleep && src_rise && !wr && !special_hit)
      |=> inc_tick)
    else $error("synchronized edge not counted one cycle later");

  a_read_count_byte: assert property (
    (rd && addr == AST_OFS_CNT_HI) |=> (rdata == $past(count_high_byte)))
    else $error("count high byte read wrong");

  a_read_count_low: assert property (
    (rd && addr == AST_OFS_CNT_LO) |=> (rdata == $past(count_low_byte)))
    else $error("count low byte read wrong");

  a_write_hi_lands: assert property (
    wr_hi |=> (count_high_byte == $past(wdata)))
    else $error("count high byte write lost");

  a_trig_event_out: assert property (
    special_hit |=> special_event)
    else $error("special trigger not reported");

  a_no_trig_quiet: assert property (
    !special_hit |=> !special_event)
    else $error("special event without trigger");

  a_flag_no_spurious: assert property (
    (!status[AST_FLAG_OVF] && !ovf_evt) |=> !status[AST_FLAG_OVF])
    else $error("overflow flag set without rollover");

  a_flag_read_clears: assert property (
    (rd_flag && !ovf_evt) |=> !status[AST_FLAG_OVF])
    else $error("flag read did not clear overflow flag");

  a_flag_set_wins: assert property (
    (rd_flag && ovf_evt) |=> status[AST_FLAG_OVF])
    else $error("rollover lost to flag read");

  a_flag_sticky: assert property (
    (status[AST_FLAG_OVF] && !rd_flag) |=> status[AST_FLAG_OVF])
    else $error("overflow flag dropped without read");

  a_irq_unmasked: assert property (
    (status[AST_FLAG_OVF] && mask[AST_FLAG_OVF] && !rd_flag) |=> irq)
    else $error("unmasked flag gave no interrupt");

  a_irq_masked_low: assert property (
    (mask == '0) |=> !irq)
    else $error("masked flag raised interrupt");

  a_osc_amp_off: assert property (
    !osc_en |=> !crystal_amp_oe)
    else $error("crystal amplifier driven while off");

  a_base_back_sync: assert property (
    !unsync |=> timebase_valid)
    else $error("time base withheld outside unsync mode");

  a_no_wake_awake: assert property (
    !sleep |=> !wake)
    else $error("wake raised while awake");

  a_count_holds: assert property (
    (!inc_tick && !wr_lo && !wr_hi && !special_hit) |=> $stable(count))
    else $error("count moved without a tick");

  a_osc_amp_enable: assert property (
    osc_en ##1 osc_en |-> crystal_amp_oe)
    else $error("crystal amplifier not enabled");

  a_wake_on_irq: assert property (
    (irq && sleep) |=> wake)
    else $error("overflow interrupt did not wake");

  c_overflow: cover property (ovf_evt);
  c_special_reset: cover property (special_hit ##1 count == AST_CNT_ZERO);
  c_sleep_count: cover property (unsync && sleep && inc_tick);
  c_write_vs_trig: cover property (wr_lo && special_hit);
endmodule
`default_nettype wire

// ===== ast_pkg.sv
// constants and register map of the async sixteen-bit timer
package ast_pkg;
  // register offsets
  localparam int AST_AW = 3;
  localparam logic [2:0] AST_OFS_CNT_LO = 3'h0;
  localparam logic [2:0] AST_OFS_CNT_HI = 3'h1;
  localparam logic [2:0] AST_OFS_CTRL = 3'h2;
  localparam logic [2:0] AST_OFS_FLAG = 3'h3;
  localparam logic [2:0] AST_OFS_MASK = 3'h4;
  localparam logic [2:0] AST_OFS_CMP_LO = 3'h5;
  localparam logic [2:0] AST_OFS_CMP_HI = 3'h6;
  localparam logic [2:0] AST_OFS_CMP_MODE = 3'h7;
  // timer_control_register fields
  localparam int AST_CTL_ON = 0;
  localparam int AST_CTL_EXT = 1;
  localparam int AST_CTL_SYNC_DIS = 2;
  localparam int AST_CTL_OSC_EN = 3;
  localparam int AST_CTL_W = 4;
  // peripheral_flag_register fields
  localparam int AST_FLAG_OVF = 0;
  localparam int AST_FLAG_W = 1;
  // compare_mode_field
  localparam int AST_MODE_W = 4;
  localparam logic [3:0] AST_MODE_SPECIAL = 4'hb;
  // reset values and count limits
  localparam logic [7:0] AST_BYTE_ZERO = 8'h00;
  localparam logic [3:0] AST_CTL_RST = 4'h0;
  localparam logic [3:0] AST_MODE_RST = 4'h0;
  localparam logic [15:0] AST_CNT_ZERO = 16'h0000;
  localparam logic [15:0] AST_CNT_MAX = 16'hffff;
  localparam logic [15:0] AST_CNT_ONE = 16'h0001;
endpackage

// ===== ast_sync.sv
// two-flop synchronizer with rising edge detection
`timescale 1ns/100ps
`default_nettype none
module ast_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous input
  input wire logic async_in,
  // synchronized level and one-cycle rising pulse
  output logic level,
  output logic rise
);
  logic meta;
  logic last;

  // first flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= async_in;
      level <= meta;
    end
  end

  // edge detect on the settled level only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
      rise <= 1'b0;
    end else begin
      last <= level;
      rise <= level & ~last;
    end
  end
endmodule
`default_nettype wire

// ===== ast_irq.sv
// sticky status bits, read-to-clear, masked onto one level interrupt
`timescale 1ns/100ps
`default_nettype none
module ast_irq #(
  parameter int N = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and software side
  input wire logic [N-1:0] set,
  input wire logic clr,
  input wire logic [N-1:0] mask,
  // state
  output logic [N-1:0] status,
  output logic irq
);
  logic [N-1:0] next_status;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    next_status = (status & ~{N{clr}}) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & mask);
    end
  end
endmodule
`default_nettype wire

// ===== ast_clk_src.sv
// partner model: external count clock and crystal, both still between bursts
`timescale 1ns/100ps
`default_nettype none
module ast_clk_src (
  // burst request
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic use_xtal,
  input wire logic amp_oe,
  // pins and status
  output logic ext_clk,
  output logic xtal_pin,
  output logic busy
);
  // idle level of both pins
  initial begin
    ext_clk = 1'b0;
    xtal_pin = 1'b0;
    busy = 1'b0;
  end
  // count rising edges at 80 ns, the first 3 ns after start rises
  always @(posedge start) begin
    busy = 1'b1;
    #3;
    repeat (count) begin
      // a crystal only swings while the device drives its amplifier
      if (use_xtal) xtal_pin = amp_oe;
      else ext_clk = 1'b1;
      #40;
      ext_clk = 1'b0;
      xtal_pin = 1'b0;
      #40;
    end
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// ===== ast_timer_tb_top.sv
// self-checking bench for the sixteen-bit timer
`timescale 1ns/100ps
`default_nettype none
module ast_timer_tb_top;
  import ast_pkg::*;
  logic clk, rst_n, wr, rd, sleep, go, use_xtal;
  logic rd_q = 1'b0;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, n, r;
  logic ext_clk, xtal, amp_oe, amp_out, tb_valid, sp_ev, irq, wake, busy;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr;
  logic [15:0] v;
  int mismatches, tests_run, gap;

  ast_timer u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sleep(sleep), .ext_clk(ext_clk), .crystal_input_pin(xtal),
    .crystal_amp_output_pin(amp_out), .crystal_amp_oe(amp_oe), .timebase_valid(tb_valid),
    .special_event(sp_ev), .irq(irq), .wake(wake));
  ast_clk_src u_src (.start(go), .count(n), .use_xtal(use_xtal), .amp_oe(amp_oe),
    .ext_clk(ext_clk), .xtal_pin(xtal), .busy(busy));

  // core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    mismatches++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) fail(msg);
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) fail(msg);
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // the expected byte is noted now and compared when the data appear
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic burst(input logic x, input logic [7:0] k);
    int i = 0;
    use_xtal <= x;
    n <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy && i < 2000) begin
      @(posedge clk);
      i++;
    end
    if (busy) begin
      fail("burst hang");
      test_done();
    end
    // let the synchronizer and increment land
    repeat (6) @(posedge clk);
  endtask

  task automatic wait_sp(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (sp_ev !== 1'b1 && c < 300);
    if (c >= 300) begin
      fail("no trigger");
      test_done();
    end
  endtask

  // read data stand one cycle after the strobe only
  always @(posedge clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        tests_run++;
        fail("unexpected read");
      end else begin
        check_byte(rdata, exp_q.pop_front(), "read data");
      end
    end
    rd_q <= rd;
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    sleep = 1'b0;
    go = 1'b0;
    use_xtal = 1'b0;
    n = 8'h00;
    mismatches = 0;
    tests_run = 0;
    lfsr = 32'h38fe_8bf4;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(AST_OFS_CTRL, 8'h00);
    rd_reg(AST_OFS_CMP_MODE, 8'h00);
    // count == compare == 0 keeps the trigger standing while a count write lands
    wr_reg(AST_OFS_CMP_MODE, {4'h0, AST_MODE_SPECIAL});
    wr_reg(AST_OFS_CNT_LO, 8'h33);
    rd_reg(AST_OFS_CNT_LO, 8'h33);
    wr_reg(AST_OFS_CNT_LO, 8'h00);
    // special trigger: compare pair acts as period, no overflow flag
    lfsr = next_rand(lfsr);
    v = {13'h0000, lfsr[2:0]} + 16'h0004;
    wr_reg(AST_OFS_CMP_LO, v[7:0]);
    wr_reg(AST_OFS_CMP_HI, 8'h00);
    wr_reg(AST_OFS_CMP_MODE, {4'h0, AST_MODE_SPECIAL});
    wr_reg(AST_OFS_CTRL, 8'h01);
    wait_sp(gap);
    wait_sp(gap);
    check_bit(gap == int'(v) + 1, 1'b1, "period");
    check_bit(tb_valid, 1'b1, "timebase");
    wr_reg(AST_OFS_CTRL, 8'h00);
    rd_reg(AST_OFS_FLAG, 8'h00);
    // rollover sets the flag, mask gates irq, read clears
    wr_reg(AST_OFS_CMP_MODE, 8'h00);
    wr_reg(AST_OFS_MASK, 8'h01);
    wr_reg(AST_OFS_CNT_LO, 8'hfe);
    wr_reg(AST_OFS_CNT_HI, 8'hff);
    wr_reg(AST_OFS_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    wr_reg(AST_OFS_CTRL, 8'h00);
    sleep <= 1'b1;
    repeat (3) @(negedge clk);
    check_bit(irq, 1'b1, "irq");
    check_bit(wake, 1'b1, "wake");
    @(posedge clk);
    sleep <= 1'b0;
    wr_reg(AST_OFS_MASK, 8'h00);
    repeat (2) @(negedge clk);
    check_bit(irq, 1'b0, "masked irq");
    wr_reg(AST_OFS_MASK, 8'h01);
    rd_reg(AST_OFS_FLAG, 8'h01);
    rd_reg(AST_OFS_FLAG, 8'h00);
    repeat (2) @(negedge clk);
    check_bit(irq, 1'b0, "irq clear");
    // synchronized counter halts in sleep, counts when awake
    wr_reg(AST_OFS_CNT_LO, 8'h00);
    wr_reg(AST_OFS_CNT_HI, 8'h00);
    wr_reg(AST_OFS_CTRL, 8'h03);
    sleep <= 1'b1;
    burst(1'b0, 8'h04);
    sleep <= 1'b0;
    rd_reg(AST_OFS_CNT_LO, 8'h00);
    lfsr = next_rand(lfsr);
    burst(1'b0, {4'h0, lfsr[3:0]} + 8'h01);
    rd_reg(AST_OFS_CNT_LO, {4'h0, lfsr[3:0]} + 8'h01);
    // unsynchronized counter runs in sleep and ignores the trigger
    wr_reg(AST_OFS_CTRL, 8'h00);
    lfsr = next_rand(lfsr);
    r = lfsr[7:0];
    wr_reg(AST_OFS_CNT_LO, r);
    wr_reg(AST_OFS_CNT_HI, 8'h00);
    v = {8'h00, r} + 16'h0001;
    wr_reg(AST_OFS_CMP_LO, v[7:0]);
    wr_reg(AST_OFS_CMP_HI, v[15:8]);
    wr_reg(AST_OFS_CMP_MODE, {4'h0, AST_MODE_SPECIAL});
    wr_reg(AST_OFS_CTRL, 8'h07);
    sleep <= 1'b1;
    lfsr = next_rand(lfsr);
    burst(1'b0, {4'h0, lfsr[3:0]} + 8'h03);
    check_bit(tb_valid, 1'b0, "timebase");
    sleep <= 1'b0;
    v = {8'h00, r} + {12'h000, lfsr[3:0]} + 16'h0003;
    rd_reg(AST_OFS_CNT_LO, v[7:0]);
    rd_reg(AST_OFS_CNT_HI, v[15:8]);
    // crystal oscillator drives the count when enabled
    wr_reg(AST_OFS_CTRL, 8'h00);
    wr_reg(AST_OFS_CMP_MODE, 8'h00);
    wr_reg(AST_OFS_CNT_LO, 8'h00);
    wr_reg(AST_OFS_CNT_HI, 8'h00);
    wr_reg(AST_OFS_CTRL, 8'h0b);
    repeat (2) @(negedge clk);
    check_bit(amp_oe, 1'b1, "osc enable");
    check_bit(amp_out, 1'b1, "amp out");
    burst(1'b1, 8'h05);
    rd_reg(AST_OFS_CNT_LO, 8'h05);
    wr_reg(AST_OFS_CTRL, 8'h00);
    repeat (2) @(negedge clk);
    check_bit(amp_oe, 1'b0, "osc disable");
    check_bit(amp_out, 1'b0, "amp out off");
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
